/* kwu_cfg.svh */
`ifndef KWU_CFG_SVH
`define KWU_CFG_SVH

// Register byte addresses
`define KWU_ADDR_ENABLE     12'hF9F
`define KWU_ADDR_CTRL       12'hFA0
`define KWU_ADDR_STATUS     12'hFA1

// Enable register layout: pin enables sit in the upper nibble
`define KWU_EN_LSB          3'h4
`define KWU_EN_RESET        4'h0

// Control register fields
`define KWU_CTRL_LEVEL_BIT  3'h0
`define KWU_CTRL_HALT_BIT   3'h1
`define KWU_CTRL_LEVEL_RST  1'h0

// Status register fields
`define KWU_STAT_PIN_LSB    3'h0
`define KWU_STAT_HALT_BIT   3'h4
`define KWU_STAT_WAKE_BIT   3'h5
`define KWU_STAT_LEVEL_BIT  3'h6
`define KWU_STAT_RPIN_BIT   3'h7

// Bus idle values
`define KWU_RDATA_IDLE      8'h00
`define KWU_WO_READ         8'h00

`endif

/* kwu_pkg.sv */
package kwu_pkg;

    // Halt controller states, one-hot
    typedef enum logic [1:0] {
        KWU_RUN  = 2'b01,
        KWU_HALT = 2'b10
    } kwu_state_type;

endpackage : kwu_pkg

/* kwu_halt_release.sv */
// Notes on behaviour
// - Halt is released by the halt-release pin and by four key-wakeup pins.
// - Each key-wakeup pin has its own enable bit as a release source.
// - Enables for key pins 3..0 are bits 7..4; 0 disables, 1 enables.
// - Enable register is write-only; upper bits clear at reset, lower undefined.
// - While halted in level mode, a low level on an enabled key pin releases halt.
// - Level mode: pin high or enabled key low; edge mode: pin rising only.
// - Halt entry with a wake condition present starts warm-up, no halt.
// - The halt-release pin has no enable; it releases halt when high in level mode, on a rising edge in edge mode.
// - Each key pin's present level is readable; threshold may differ.
`include "kwu_cfg.svh"

module kwu_halt_release #(
    parameter int KEY_PINS = 4
) (
    input  wire logic                clk_sys_i,
    input  wire logic                resetn_i,
    input  wire logic [11:0]         addr_i,
    input  wire logic [7:0]          wdata_i,
    input  wire logic                wr_i,
    input  wire logic                rd_i,
    output logic      [7:0]          rdata_o,
    input  wire logic                halt_pin_i,
    input  wire logic [KEY_PINS-1:0] key_wake_pin_i,
    output logic                     halt_o,
    output logic                     warmup_start_o,
    output logic                     wake_req_o
);

    // Address match used by both write and read decode
    function automatic logic hit(input logic [11:0] a, input logic [11:0] ref_a);
        hit = (a == ref_a);
    endfunction : hit

    // Halt controller state
    kwu_pkg::kwu_state_type state_r;
    kwu_pkg::kwu_state_type state_nxt;
    // Software-written enables and release mode
    logic [KEY_PINS-1:0]    key_en_r;
    logic [KEY_PINS-1:0]    key_en_nxt;
    logic                   level_mode_r;
    logic                   level_mode_nxt;
    // Registered pin history and output flops
    logic                   pin_prev_r;
    logic                   halt_r;
    logic                   halt_nxt;
    logic                   warm_r;
    logic                   warm_nxt;
    logic                   wake_r;
    logic [7:0]             rdata_r;
    logic [7:0]             rdata_nxt;
    // Combinational wake terms; the edge term also needs the clocked pin_prev_r sample
    logic [KEY_PINS-1:0]    key_low_en;
    logic                   key_wake;
    logic                   level_wake;
    logic                   edge_wake;
    logic                   wake_req;
    logic                   halt_cmd;
    logic                   entry_wake;

    // Per-pin gating; a disabled pin never contributes
    // Gating ahead of the OR keeps a floating disabled pin from waking
    genvar g;
    generate
        for (g = 0; g < KEY_PINS; g++) begin : g_key
            assign key_low_en[g] = key_en_r[g] & ~key_wake_pin_i[g];
        end
    endgenerate

    // Wake request; the level path is combinational, the edge path uses the clocked pin_prev_r sample
    assign key_wake   = |key_low_en;
    assign level_wake = halt_pin_i | key_wake;
    // Edge mode ignores key pins; the previous pin sample stands in for
    // the edge detector, a clocked model of the stopped-clock latch
    assign edge_wake  = halt_pin_i & ~pin_prev_r;
    assign wake_req   = level_mode_r ? level_wake : edge_wake;
    // Entry check looks at the pin level, not its edge, so a pin that is
    // already high turns a halt into a warm-up in either mode; keys are
    // release sources only in level mode
    assign entry_wake = halt_pin_i | (level_mode_r & key_wake);
    assign halt_cmd   = wr_i & hit(addr_i, `KWU_ADDR_CTRL) & wdata_i[`KWU_CTRL_HALT_BIT];

    // Register writes; only the upper nibble of the enable register is kept
    // The lower nibble has no storage at all, which saves four flops
    always_comb begin
        key_en_nxt     = key_en_r;
        level_mode_nxt = level_mode_r;
        if (wr_i && hit(addr_i, `KWU_ADDR_ENABLE)) begin
            key_en_nxt = wdata_i[`KWU_EN_LSB +: KEY_PINS];
        end else if (wr_i && hit(addr_i, `KWU_ADDR_CTRL)) begin
            level_mode_nxt = wdata_i[`KWU_CTRL_LEVEL_BIT];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            key_en_r     <= KEY_PINS'(`KWU_EN_RESET);
            level_mode_r <= `KWU_CTRL_LEVEL_RST;
        end else begin
            key_en_r     <= key_en_nxt;
            level_mode_r <= level_mode_nxt;
        end
    end

    // Halt controller; a halt command while halted is simply ignored
    // Limitation: the clock is modelled as running while halted, so the
    // edge-mode detector can only see an edge after one low sample
    always_comb begin
        state_nxt = state_r;
        halt_nxt  = halt_r;
        warm_nxt  = 1'b0;
        case (state_r)
            kwu_pkg::KWU_RUN: begin
                if (halt_cmd && entry_wake) begin
                    warm_nxt = 1'b1;
                end else if (halt_cmd) begin
                    state_nxt = kwu_pkg::KWU_HALT;
                    halt_nxt  = 1'b1;
                end
            end
            kwu_pkg::KWU_HALT: begin
                if (wake_req) begin
                    state_nxt = kwu_pkg::KWU_RUN;
                    halt_nxt  = 1'b0;
                    warm_nxt  = 1'b1;
                end
            end
            default: begin
                state_nxt = kwu_pkg::KWU_RUN;
                halt_nxt  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            state_r    <= kwu_pkg::KWU_RUN;
            halt_r     <= 1'b0;
            warm_r     <= 1'b0;
            wake_r     <= 1'b0;
            pin_prev_r <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            halt_r     <= halt_nxt;
            warm_r     <= warm_nxt;
            wake_r     <= wake_req;
            pin_prev_r <= halt_pin_i;
        end
    end

    // Read path; the enable register is write-only and reads as zero
    // Unmapped addresses fall through to the idle value
    always_comb begin
        rdata_nxt = `KWU_RDATA_IDLE;
        if (rd_i && hit(addr_i, `KWU_ADDR_ENABLE)) begin
            rdata_nxt = `KWU_WO_READ;
        end else if (rd_i && hit(addr_i, `KWU_ADDR_CTRL)) begin
            rdata_nxt[`KWU_CTRL_LEVEL_BIT] = level_mode_r;
        end else if (rd_i && hit(addr_i, `KWU_ADDR_STATUS)) begin
            // Digital pin view; the wake threshold may disagree near mid-rail
            rdata_nxt[`KWU_STAT_PIN_LSB +: KEY_PINS] = key_wake_pin_i;
            rdata_nxt[`KWU_STAT_HALT_BIT]  = halt_r;
            rdata_nxt[`KWU_STAT_WAKE_BIT]  = wake_req;
            rdata_nxt[`KWU_STAT_LEVEL_BIT] = level_mode_r;
            rdata_nxt[`KWU_STAT_RPIN_BIT]  = halt_pin_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            rdata_r <= `KWU_RDATA_IDLE;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Outputs straight from flops
    // so downstream timing never sees the combinational wake path
    assign rdata_o        = rdata_r;
    assign halt_o         = halt_r;
    assign warmup_start_o = warm_r;
    assign wake_req_o     = wake_r;

    // Most checks below look at registered outputs, so a slip in the
    // combinational wake path shows up one cycle later on the pins
    // Entering halt with no wake pending stops the clock next cycle
    halt_entry_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (state_r == kwu_pkg::KWU_RUN) && halt_cmd && !halt_pin_i && !(level_mode_r && key_wake)
        |=> halt_o && !warmup_start_o);

    // Pending wake at entry turns into warm-up, no halt
    early_release_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (state_r == kwu_pkg::KWU_RUN) && halt_cmd && (halt_pin_i || (level_mode_r && key_wake))
        |=> !halt_o && warmup_start_o);

    // Enabled low key pin releases halt in level mode
    key_release_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        halt_o && level_mode_r && |(key_en_r & ~key_wake_pin_i)
        |=> !halt_o && warmup_start_o);

    // Disabled or high key pins hold halt in level mode
    key_disabled_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        halt_o && level_mode_r && !halt_pin_i && ((~key_en_r | key_wake_pin_i) == '1)
        |=> halt_o);

    // Release pin high always releases in level mode
    pin_level_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        halt_o && level_mode_r && halt_pin_i |=> !halt_o ##0 warmup_start_o);

    // Edge mode ignores key pins and a steady-high pin
    edge_keys_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        halt_o && !level_mode_r && !(halt_pin_i && !$past(halt_pin_i))
        |=> halt_o);

    // Rising edge of the release pin ends halt in edge mode
    edge_rise_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        halt_o && !level_mode_r && $rose(halt_pin_i) |=> !halt_o);

    // Enable write steers key gating from the upper nibble
    enable_write_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        wr_i && hit(addr_i, `KWU_ADDR_ENABLE)
        |=> key_en_r == $past(wdata_i[`KWU_EN_LSB +: KEY_PINS]));

    // Write-only register reads back zero
    enable_read_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        rd_i && hit(addr_i, `KWU_ADDR_ENABLE) |=> rdata_o == `KWU_WO_READ);

    // Status shows key pin levels of the read cycle
    pin_status_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        rd_i && hit(addr_i, `KWU_ADDR_STATUS)
        |=> rdata_o[`KWU_STAT_PIN_LSB +: KEY_PINS] == $past(key_wake_pin_i));

    // Warm-up is never asserted while halt is asserted
    warm_run_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        warmup_start_o
        |-> !halt_o);

    // Warm-up follows either a halt command or a halted cycle
    warm_cause_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        warmup_start_o
        |-> $past(halt_cmd) || $past(halt_o));

    // Halt holds, with no warm-up, while nothing asks for release
    halt_hold_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        halt_o && !wake_req
        |=> halt_o && !warmup_start_o);

    // Halt is only ever entered by a command
    halt_by_cmd_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !halt_o && !halt_cmd
        |=> !halt_o);

    // Level mode wake request follows pin high or an enabled low key
    wake_level_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        level_mode_r && (halt_pin_i || |(key_en_r & ~key_wake_pin_i))
        |=> wake_req_o);

    // Low release pin and no enabled low key in level mode means no request
    wake_quiet_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !halt_pin_i && (!level_mode_r || (key_en_r & ~key_wake_pin_i) == '0)
        |=> !wake_req_o);

    // Edge mode gives no request for a pin that stays high
    edge_steady_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !level_mode_r && $past(resetn_i) && halt_pin_i && $past(halt_pin_i)
        |=> !wake_req_o);

    // Enables change only on a write to their register
    enable_hold_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !(wr_i && hit(addr_i, `KWU_ADDR_ENABLE))
        |=> $stable(key_en_r));

    // Mode select takes the written bit
    mode_write_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        wr_i && hit(addr_i, `KWU_ADDR_CTRL)
        |=> level_mode_r == $past(wdata_i[`KWU_CTRL_LEVEL_BIT]));

    // Control read shows the mode in force at the strobe
    ctrl_read_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        rd_i && hit(addr_i, `KWU_ADDR_CTRL)
        |=> rdata_o[`KWU_CTRL_LEVEL_BIT] == $past(level_mode_r));

    // Status shows the halt state of the read cycle
    status_halt_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        rd_i && hit(addr_i, `KWU_ADDR_STATUS)
        |=> rdata_o[`KWU_STAT_HALT_BIT] == $past(halt_o));

    // Status shows the release pin level of the read cycle
    status_pin_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        rd_i && hit(addr_i, `KWU_ADDR_STATUS)
        |=> rdata_o[`KWU_STAT_RPIN_BIT] == $past(halt_pin_i));

    // Read data stand one cycle only, idle otherwise
    rdata_idle_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !rd_i
        |=> rdata_o == `KWU_RDATA_IDLE);

    // An enabled low key at entry in level mode blocks the halt
    entry_key_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (state_r == kwu_pkg::KWU_RUN) && halt_cmd && level_mode_r && key_wake
        |=> !halt_o && warmup_start_o);

    // A steady-high release pin at entry in edge mode blocks the halt
    entry_edge_pin_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (state_r == kwu_pkg::KWU_RUN) && halt_cmd && !level_mode_r && halt_pin_i
        |=> !halt_o && warmup_start_o);

endmodule : kwu_halt_release

/* kwu_key_model.sv */
// Keys and halt-release switch on the far side of the pins
module kwu_key_model (
    input  wire logic       clk_sys_i,
    input  wire logic       slow_i,
    input  wire logic       halt_lvl_i,
    input  wire logic [3:0] key_lvl_i,
    output logic            halt_pin_o,
    output logic [3:0]      key_wake_pin_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [4:0] dly_r [0:2];

    // Slow contacts settle three cycles late, so the block must not rely on prompt edges
    always @(posedge clk_sys_i) begin
        dly_r[0] <= {halt_lvl_i, key_lvl_i};
        dly_r[1] <= dly_r[0];
        dly_r[2] <= dly_r[1];
    end

    // Push-pull drivers; the stimulus keeps the release pin low while keys wake
    assign {halt_pin_o, key_wake_pin_o} = slow_i ? dly_r[2] : {halt_lvl_i, key_lvl_i};
endmodule : kwu_key_model

/* kwu_halt_release_tb_top.sv */
module kwu_halt_release_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_sys_i = 1'b0, resetn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, rd_d = 1'b0;
    logic        halt_lvl = 1'b0, slow = 1'b0, halt_pin, halt_o, warmup_start_o, wake_req_o;
    logic [11:0] addr_i = 12'h000;
    logic [7:0]  wdata_i = 8'h00, rdata_o;
    logic [3:0]  key_lvl = 4'hF, key_pin, keys;
    logic [7:0]  rd_q[$], wk_q[$];
    int          failures = 0, checks = 0;

    always #4 clk_sys_i = ~clk_sys_i;

    kwu_key_model i_kwu_key_model (.clk_sys_i(clk_sys_i), .slow_i(slow), .halt_lvl_i(halt_lvl),
        .key_lvl_i(key_lvl), .halt_pin_o(halt_pin), .key_wake_pin_o(key_pin));
    kwu_halt_release i_kwu_halt_release (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .halt_pin_i(halt_pin), .key_wake_pin_i(key_pin), .halt_o(halt_o),
        .warmup_start_o(warmup_start_o), .wake_req_o(wake_req_o));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_of_test;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_of_test

    // One-cycle strobes, with an idle cycle between accesses
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk_sys_i);
        addr_i <= a; rd_i <= 1'b1; rd_q.push_back(exp);
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
    endtask : rd

    task automatic set_pins(input logic hl, input logic [3:0] kl, input logic sl);
        @(posedge clk_sys_i);
        halt_lvl <= hl; key_lvl <= kl; slow <= sl;
        repeat (4) @(posedge clk_sys_i);
    endtask : set_pins

    // Mode written first, since a halt in the same write still sees the old mode
    task automatic halt_cmd(input logic [7:0] mode, input logic now_wake);
        wr(12'hFA0, mode);
        if (now_wake) wk_q.push_back(8'h01);
        wr(12'hFA0, mode | 8'h02);
        repeat (3) @(negedge clk_sys_i);
        chk({7'h00, halt_o}, {7'h00, ~now_wake});
        chk({7'h00, wake_req_o}, {7'h00, now_wake & mode[0]});
    endtask : halt_cmd

    task automatic release_pins(input logic hl, input logic [3:0] kl);
        wk_q.push_back(8'h01);
        set_pins(hl, kl, slow);
        repeat (4) @(negedge clk_sys_i);
        chk({7'h00, halt_o}, 8'h00);
    endtask : release_pins

    // Watcher: read data in the cycle after the strobe, each warm-up pulse against a note
    always @(posedge clk_sys_i) begin
        if (rd_d) chk(rdata_o, rd_q.size() ? rd_q.pop_front() : 8'hEE);
        if (warmup_start_o === 1'b1) chk(8'h01, wk_q.size() ? wk_q.pop_front() : 8'h00);
        rd_d <= rd_i;
    end

    // Hang guard, well beyond the few hundred cycles the sequence needs
    initial begin
        repeat (3000) @(posedge clk_sys_i);
        failures++;
        end_of_test();
    end

    initial begin
        void'($urandom(42479));
        keys = 4'($urandom);
        repeat (12) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        key_lvl <= keys;
        rd(12'hF9F, 8'h00);
        rd(12'hFFF, 8'h00);
        rd(12'hFA1, {4'h0, keys});
        wr(12'hF9F, {4'hF, keys});
        rd(12'hF9F, 8'h00);
        // One enabled key at a time, the disabled ones held low; keys 1 and 3 through the slow contacts
        for (int k = 0; k < 4; k++) begin
            wr(12'hF9F, 8'h10 << k);
            set_pins(1'b0, 4'h1 << k, k[0]);
            halt_cmd(8'h01, 1'b0);
            rd(12'hFA1, {4'b0101, 4'h1 << k});
            release_pins(1'b0, 4'h0);
            halt_cmd(8'h01, 1'b1);
        end
        // Release pin alone, no key enabled, level then edge mode
        wr(12'hF9F, 8'h00);
        set_pins(1'b0, 4'h0, 1'b0);
        halt_cmd(8'h01, 1'b0);
        release_pins(1'b1, 4'h0);
        halt_cmd(8'h01, 1'b1);
        set_pins(1'b0, 4'hF, 1'b1);
        halt_cmd(8'h00, 1'b0);
        release_pins(1'b1, 4'hF);
        halt_cmd(8'h00, 1'b1);
        repeat (4) @(posedge clk_sys_i);
        chk(8'(wk_q.size()), 8'h00);
        end_of_test();
    end
endmodule : kwu_halt_release_tb_top
